/* File: hw/sadc_cfg.svh */
// Register offsets, field positions, reset values and timing constants of the slope converter
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
// Register indices; the byte address on the bus is four times the index
`define SADC_OFS_CTRL0 8'h1f
`define SADC_OFS_CTRL1 8'h9f
`define SADC_RST_CTRL0 8'h02
`define SADC_RST_CTRL1 8'h00
`define SADC_CH_HI 7
`define SADC_CH_LO 4
`define SADC_BIT_UNUSED 3
`define SADC_BIT_MUXOE 2
`define SADC_BIT_RRST 1
`define SADC_BIT_ZERO 0
`define SADC_CUR_HI 7
`define SADC_CUR_LO 4
`define SADC_PCB_HI 3
`define SADC_PCB_LO 2
`define SADC_PCA_HI 1
`define SADC_PCA_LO 0
`define SADC_CH_RSVD0 4'he
`define SADC_CH_COUNT 16
`define SADC_CUR_OFF 4'h0
`define SADC_CUR_STEP_NA 2250
`define SADC_RRST_MIN_NS 200000
`define SADC_CLK_NS 10
`define SADC_RRST_MIN_CYC ((`SADC_RRST_MIN_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2
`endif

/* File: hw/sadc_pkg.sv */
// Types shared by the slope converter control files
package sadc_pkg;
  // Register one: channel, unused bit, mux enable, ramp reset, zero select
  typedef struct packed {
    logic [3:0] channel_select;
    logic unused_bit;
    logic mux_to_pin_enable;
    logic ramp_reset;
    logic zero_current_select;
  } sadc_ctrl0_type;
  // Register two: current code and two pin group configurations
  typedef struct packed {
    logic [3:0] ramp_current_select;
    logic [1:0] pin_group_config_hi;
    logic [1:0] pin_group_config_lo;
  } sadc_ctrl1_type;
  // Analog control bundle toward the analog macro
  typedef struct packed {
    logic [15:0] mux_sel_onehot;
    logic [14:0] ramp_current_leg;
    logic discharge;
    logic timer_stop;
    logic mux_to_pin;
    logic zero_enable;
  } sadc_analog_type;
  // Bus slave states
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_WRESP,
    SADC_RDATA
  } sadc_bus_state_type;
endpackage

/* File: hw/sadc_chan_decode.sv */
// Channel code to one-hot analog mux select
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_chan_decode (
  input wire logic [3:0] code_i,
  output logic [15:0] onehot_o
);
  ////////////////////////////////////////////////////////////////////////////
  // One mux switch per code; reserved codes close no switch
  genvar g;
  generate
    for (g = 0; g < `SADC_CH_COUNT; g++) begin : gen_sw
      if (g >= `SADC_CH_RSVD0) begin : gen_rsvd
        assign onehot_o[g] = 1'b0; // RULE16
      end else begin : gen_live
        assign onehot_o[g] = (code_i == 4'(g)); // RULE1 RULE3
      end
    end
  endgenerate
endmodule

/* File: hw/sadc_pin_config.sv */
// Two-bit pin group code to per-pin digital enables
`timescale 1ns/1ps
module sadc_pin_config (
  input wire logic [1:0] cfg_i,
  output logic [3:0] digital_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Thermometer decode, top down: codes 1 and 2 each add one digital pin, code 3 turns all four digital
  always_comb begin
    case (cfg_i) // RULE14
      2'h0: digital_o = 4'h0;
      2'h1: digital_o = 4'h8;
      2'h2: digital_o = 4'hc;
      default: digital_o = 4'hf;
    endcase
  end
endmodule

/* File: hw/sadc_ctrl.sv */
// Slope converter mux, ramp current and pin configuration control with AXI4-Lite registers
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sadc_cfg.svh"
// Operation
// RULE1: exactly one of sixteen channels reaches comparator; here codes 14 and 15 connect no channel
// RULE2: channel code from first register upper nibble
// RULE3: codes map pins, internal references, more pins
// RULE4: current code in second register upper nibble
// RULE5: code zero disables every current source
// RULE6: ramp reset stops timer, discharges capacitor
// RULE7: ramp reset disables current sources internally
// RULE8: current flows once ramp reset clears
// RULE9: software holds ramp reset 200 us
// RULE10: mux enable drives mux onto pin zero
// RULE11: zero select enables zeroing on two inputs
// RULE12: first register bit three reads zero
// RULE13: second register low nibble configures pin groups
// RULE14: config code turns pins digital top down
// RULE15: both registers readable and writable
// RULE16: reserved channel codes connect no source
module sadc_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [9:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [9:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output sadc_pkg::sadc_analog_type analog_o,
  output logic [3:0] first_port_digital_o,
  output logic [3:0] second_port_digital_o,
  output logic ramp_reset_short_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Register state
  sadc_pkg::sadc_ctrl0_type ctrl0; // First control register
  sadc_pkg::sadc_ctrl0_type next_ctrl0;
  sadc_pkg::sadc_ctrl1_type ctrl1; // Second control register
  sadc_pkg::sadc_ctrl1_type next_ctrl1;
  // Write channel capture, either order accepted
  logic aw_held;
  logic next_aw_held;
  // Byte address; bits 1:0 are ignored, bits 9:2 are the register index
  logic [9:0] aw_addr;
  logic [9:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [7:0] w_data;
  logic [7:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic bvalid;
  logic next_bvalid;
  // Read channel
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  // Discharge time monitor
  logic [15:0] rrst_cnt;
  logic [15:0] next_rrst_cnt;
  logic rrst_short;
  logic next_rrst_short;
  // Analog control outputs registered
  sadc_pkg::sadc_analog_type analog;
  sadc_pkg::sadc_analog_type next_analog;
  logic [3:0] port_a_dig;
  logic [3:0] port_d_dig;
  logic [15:0] mux_onehot;
  logic do_write;
  // Per-leg enables before they are gathered into the analog bundle
  logic [14:0] leg_on;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational decoders
  sadc_chan_decode u_chan (
    .code_i(ctrl0.channel_select), // RULE2
    .onehot_o(mux_onehot)
  );

  sadc_pin_config u_pcfg_a (
    .cfg_i(ctrl1.pin_group_config_lo), // RULE13
    .digital_o(port_a_dig)
  );

  sadc_pin_config u_pcfg_d (
    .cfg_i(ctrl1.pin_group_config_hi), // RULE13
    .digital_o(port_d_dig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Handshake outputs; a channel is ready while not yet holding an item
  // Ready drops while a response waits, so only one write is ever in flight
  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o = !w_held && !bvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
  assign analog_o = analog;
  assign ramp_reset_short_o = rrst_short;
  assign do_write = aw_held && w_held && !bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Write path: capture address and data, then update and respond
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    // Address taken
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    // Data taken; only lane zero carries register bits
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i[7:0];
      next_w_lane0 = s_axi_wstrb_i[0];
    end
    // Both halves present: commit and answer
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `SADC_RESP_OKAY;
      // The word index picks the register; byte lanes above zero are ignored
      if (aw_addr[9:2] == `SADC_OFS_CTRL0) begin
        if (w_lane0) begin
          next_ctrl0 = w_data; // RULE15
          next_ctrl0.unused_bit = 1'b0; // RULE12
        end
      end else if (aw_addr[9:2] == `SADC_OFS_CTRL1) begin
        if (w_lane0) begin
          next_ctrl1 = w_data; // RULE15
        end
      end else begin
        // Unmapped words still answer, so a stray master never hangs
        next_bresp = `SADC_RESP_SLVERR; // Unmapped address
      end
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
  end

  // Register the write path
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= 10'h000;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SADC_RESP_OKAY;
      ctrl0 <= `SADC_RST_CTRL0; // Ramp held in reset from power-on
      ctrl1 <= `SADC_RST_CTRL1;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one-cycle answer, held until rready
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    // Reads never stall: arready is only low while an answer waits
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp = `SADC_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr_i[9:2] == `SADC_OFS_CTRL0) begin
        next_rdata[7:0] = ctrl0;
        next_rdata[`SADC_BIT_UNUSED] = 1'b0; // RULE12
      end else if (s_axi_araddr_i[9:2] == `SADC_OFS_CTRL1) begin
        next_rdata[7:0] = ctrl1; // RULE15
      end else begin
        next_rresp = `SADC_RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  // Register the read path
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SADC_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Discharge monitor: flags a ramp reset released before the minimum time.
  // Software owns the timing; this only reports a violation to the system.
  always_comb begin
    next_rrst_cnt = rrst_cnt;
    next_rrst_short = rrst_short;
    if (ctrl0.ramp_reset) begin
      // Saturating, so a long hold never wraps into a false short flag
      if (rrst_cnt != 16'(`SADC_RRST_MIN_CYC)) begin
        next_rrst_cnt = rrst_cnt + 16'h0001;
      end
    end else begin
      next_rrst_cnt = 16'h0000;
      if (analog.discharge) begin
        next_rrst_short = (rrst_cnt != 16'(`SADC_RRST_MIN_CYC)); // RULE9
      end
    end
  end

  // Register the monitor; power-on reset counts as a full discharge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rrst_cnt <= 16'(`SADC_RRST_MIN_CYC);
      rrst_short <= 1'b0;
    end else begin
      rrst_cnt <= next_rrst_cnt;
      rrst_short <= next_rrst_short;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls: ramp current legs are a thermometer of the code,
  // so current grows by one step per code value
  genvar g;
  generate
    for (g = 0; g < 15; g++) begin : gen_leg
      // Leg on when code exceeds its index and ramp is released
      assign leg_on[g] = (ctrl1.ramp_current_select > 4'(g)) // RULE4 RULE5
        && !ctrl0.ramp_reset; // RULE7 RULE8
    end
  endgenerate

  // Gather the next analog bundle; it is registered once more so the
  // analog side never sees decode glitches from a register write
  always_comb begin
    next_analog = '0;
    next_analog.ramp_current_leg = leg_on; // RULE4 RULE7
    next_analog.mux_sel_onehot = mux_onehot; // RULE1 RULE16
    // Timer stop and discharge share one source so they never disagree
    next_analog.discharge = ctrl0.ramp_reset; // RULE6
    next_analog.timer_stop = ctrl0.ramp_reset; // RULE6
    next_analog.mux_to_pin = ctrl0.mux_to_pin_enable; // RULE10
    next_analog.zero_enable = ctrl0.zero_current_select; // RULE11
  end

  // Register analog controls and port configuration
  // Pin enables lag the register by one cycle, like the analog controls
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      analog <= '0;
      analog.discharge <= 1'b1;
      analog.timer_stop <= 1'b1;
      analog.mux_sel_onehot <= 16'h0001;
      first_port_digital_o <= 4'h0;
      second_port_digital_o <= 4'h0;
    end else begin
      analog <= next_analog;
      first_port_digital_o <= port_a_dig; // RULE13 RULE14
      second_port_digital_o <= port_d_dig; // RULE13 RULE14
    end
  end
endmodule

/* File: tb/sadc_ctrl_sva.sv */
// Port checker for the slope converter control block
`timescale 1ns/1ps
module sadc_ctrl_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire sadc_pkg::sadc_analog_type analog_o,
  input wire logic [3:0] first_port_digital_o,
  input wire logic [3:0] second_port_digital_o
);
  // One clock domain, so clocking and reset are given once
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_mux_single: assert property ($countones(analog_o.mux_sel_onehot) <= 1)
    else $error("more than one mux channel selected");
  a_reset_state: assert property ($fell(rst_i) |-> analog_o.mux_sel_onehot == 16'h0001
    && analog_o.discharge) else $error("analog outputs not at reset state");
  a_legs_thermo: assert property (((analog_o.ramp_current_leg + 15'h1)
    & analog_o.ramp_current_leg) == 15'h0) else $error("current legs not contiguous");
  a_timer_disch: assert property (analog_o.timer_stop == analog_o.discharge)
    else $error("timer stop differs from discharge");
  a_legs_gated: assert property (analog_o.discharge |-> analog_o.ramp_current_leg == 15'h0)
    else $error("current leg on during discharge");
  a_pins_topdown: assert property (first_port_digital_o inside {4'h0, 4'h8, 4'hc, 4'hf}
    && second_port_digital_o inside {4'h0, 4'h8, 4'hc, 4'hf}) else $error("bad pin group");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered");
  a_rdata_byte: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_bresp_clear: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response not retired");
endmodule
bind sadc_ctrl sadc_ctrl_sva u_sva (.core_clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .analog_o,
  .first_port_digital_o, .second_port_digital_o);

/* File: tb/sadc_ramp_cap_model.sv */
// Behavioural ramp capacitor fed by the current legs
`timescale 1ns/1ps
module sadc_ramp_cap_model (
  input wire logic core_clk_i,
  input wire sadc_pkg::sadc_analog_type analog_i,
  output logic [23:0] ramp_level_o
);
  // Discharge empties it; else each active leg adds one unit a cycle, so slope tracks code
  always_ff @(posedge core_clk_i) begin
    if (analog_i.discharge) begin
      ramp_level_o <= 24'h0;
    end else begin
      ramp_level_o <= ramp_level_o + 24'($countones(analog_i.ramp_current_leg));
    end
  end
endmodule

/* File: tb/sadc_ctrl_tb.sv */
// Register level testbench for the slope converter control block
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_ctrl_tb;
  logic clk, rst, awv, wv, br, arv, rr; // Bus master state
  logic [9:0] awa, ara; // Byte addresses, four times the register index
  logic [31:0] wd; // Write data
  logic awr, wr_r, bv, arr, rv, shrt; // Slave answers
  logic [1:0] bresp, rresp;
  logic [31:0] rdat;
  logic [3:0] dg_a, dg_d; // Pin group digital enables
  logic [23:0] lvl; // Ramp level from the capacitor model
  sadc_pkg::sadc_analog_type an;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  sadc_ctrl dut (.core_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .analog_o(an),
    .first_port_digital_o(dg_a), .second_port_digital_o(dg_d), .ramp_reset_short_o(shrt));
  sadc_ramp_cap_model cap (.core_clk_i(clk), .analog_i(an), .ramp_level_o(lvl));
  ////////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 clk = ~clk;
  // Hang guard: the run needs about 20300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write both halves together, release each once taken, wait for the response
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awa <= {a, 2'h0}; // Tasks take the register index
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    ara <= {a, 2'h0};
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    chk(rdat, {24'h0, d});
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // Pin group code turns pins digital from the top pin down
  function automatic logic [31:0] dig(input logic [1:0] c);
    return {28'h0, |c, c[1], &c, &c};
  endfunction
  task report_and_stop;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    {awv, wv, br, arv, rr} = 5'h00;
    awa = 10'h000;
    ara = 10'h000;
    wd = 32'h0000_0000;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`SADC_OFS_CTRL0, 8'h02, `SADC_RESP_OKAY);
    rd(`SADC_OFS_CTRL1, 8'h00, `SADC_RESP_OKAY);
    chk({31'h0, an.timer_stop}, 32'h1);
    // Reset leaves the ramp discharging; hold it the full discharge time first
    repeat (20010) @(posedge clk);
    wr(`SADC_OFS_CTRL1, 8'h50, `SADC_RESP_OKAY);
    wr(`SADC_OFS_CTRL0, 8'h00, `SADC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({17'h0, an.ramp_current_leg}, 32'h1f);
    chk({28'h0, shrt, an.discharge, an.mux_to_pin, an.zero_enable}, 32'h0);
    chk({31'h0, lvl != 24'h0}, 32'h1);
    // Every channel code, ramp held in reset, unused bit written, mux and zero alternating
    for (int i = 0; i < 16; i++) begin
      wr(`SADC_OFS_CTRL0, {i[3:0], 1'b1, i[0], 1'b1, ~i[0]}, `SADC_RESP_OKAY);
      rd(`SADC_OFS_CTRL0, {i[3:0], 1'b0, i[0], 1'b1, ~i[0]}, `SADC_RESP_OKAY);
      chk({16'h0, an.mux_sel_onehot}, (i < 14) ? (32'h1 << i) : 32'h0);
      chk({28'h0, an.mux_to_pin, an.zero_enable, an.discharge, an.ramp_current_leg == 0},
        {28'h0, i[0], ~i[0], 2'h3});
    end
    // A brief hold is flagged by the monitor
    wr(`SADC_OFS_CTRL0, 8'h00, `SADC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({31'h0, shrt}, 32'h1);
    // Every current code and every pin group code
    for (int k = 0; k < 16; k++) begin
      wr(`SADC_OFS_CTRL1, {k[3:0], k[3:0]}, `SADC_RESP_OKAY);
      rd(`SADC_OFS_CTRL1, {k[3:0], k[3:0]}, `SADC_RESP_OKAY);
      chk({17'h0, an.ramp_current_leg}, (32'h1 << k) - 32'h1);
      chk({28'h0, dg_a}, dig(k[1:0]));
      chk({28'h0, dg_d}, dig(k[3:2]));
    end
    wr(`SADC_OFS_CTRL0, 8'h02, `SADC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({7'h0, an.ramp_current_leg, lvl[9:0]}, 32'h0);
    // Unmapped place: refused, no effect, reads zero
    wr(8'h40, 8'hff, `SADC_RESP_SLVERR);
    rd(8'h40, 8'h00, `SADC_RESP_SLVERR);
    rd(`SADC_OFS_CTRL1, 8'hff, `SADC_RESP_OKAY);
    report_and_stop();
  end
endmodule
